/* File: verilog/vecdec_defines.vh */
/*
 * Constants for the vector graph character decoder: control codes, tags,
 * incremental codes, state codes and widths.
 * Assumes inclusion by the decoder, the bound checker and the bench only.
 */
// Summary of operation
// RQ1: Each graph-mode address moves straight from current to new position, which becomes current.
// RQ2: First address after entering graph mode moves dark; later ones draw.
// RQ3: Bell as first character after graph entry makes the first vector drawn.
// RQ4: Point mode moves dark but lights the pixel at each address.
// RQ5: A position is two 10-bit coordinates, Y first then X.
// RQ6: Each coordinate is high five bits then low five bits from two characters.
// RQ7: Top two bits tag: 01 high part, 11 Y low, 10 X low.
// RQ8: Tag 01 is X high after Y low, Y high after X low.
// RQ9: Graph entry presets tag history as if X low just arrived.
// RQ10: Omitted characters keep old values; X low triggers the move.
// RQ11: Host sends X high only directly after Y low.
// RQ12: Extended-address precision bits are accepted and discarded.
// RQ13: Zero byte is ignored in every mode.
// RQ14: Escape in any mode starts a control sequence, not address data.
// RQ15: 1D graph, 1C point, 1F or 0D alpha mode.
// RQ16: 1E incremental; space pen up, P pen down, letters step eight directions.
// RQ17: Other characters end incremental mode and go out as alpha text.
// RQ18: Steps accumulate in 12 bits; upper 10 bits select the pixel.
// RQ19: Escape p to t makes later graph vectors dark.
// RQ20: Escape backquote to d or h to l makes later graph vectors written.
// RQ21: Escape question mark acts as a delete byte.
// RQ22: Escape 70-74 dark, 60-64 or 68-6C written, others ignored.
// RQ23: Each move goes out with start, end and draw flag, held by ready.
`ifndef VECDEC_DEFINES_VH
`define VECDEC_DEFINES_VH
`define C_NUL      8'h00
`define C_BEL      8'h07
`define C_CR       8'h0d
`define C_ESC      8'h1b
`define C_POINT    8'h1c
`define C_GRAPH    8'h1d
`define C_INCR     8'h1e
`define C_ALPHA    8'h1f
`define C_DEL      8'h7f
`define C_QMARK    8'h3f
`define C_SPACE    8'h20
`define C_PEN_DN   8'h50
`define C_MV_R     8'h41
`define C_MV_RU    8'h45
`define C_MV_U     8'h44
`define C_MV_LU    8'h46
`define C_MV_L     8'h42
`define C_MV_LD    8'h4a
`define C_MV_D     8'h48
`define C_MV_RD    8'h49
`define W_DARK_LO  8'h70
`define W_DARK_HI  8'h74
`define W_WR1_LO   8'h60
`define W_WR1_HI   8'h64
`define W_WR2_LO   8'h68
`define W_WR2_HI   8'h6c
`define TAG_HIGH   2'b01
`define TAG_YLOW   2'b11
`define TAG_XLOW   2'b10
`define TAG_MSB    6
`define TAG_LSB    5
`define HALF_W     5
`define FRAC_W     2
`define KIND_MOVE  2'h0
`define KIND_POINT 2'h1
`define KIND_TEXT  2'h2
`define KIND_DEL   2'h3
`define ST_ALPHA   4'h1
`define ST_GRAPH   4'h2
`define ST_POINT   4'h4
`define ST_INCR    4'h8
`define STEP_ONE   12'h001
`endif

/* File: verilog/vec_skid_buffer.v */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
module vec_skid_buffer #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input  wire             sys_clk,
   input  wire             reset,
   // Filling side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Draining side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem_r [0:1];
   reg             wptr_r;
   reg             rptr_r;
   reg [1:0]       count_r;
   wire            push;
   wire            pop;

   assign in_ready  = (count_r != 2'h2);
   assign out_valid = (count_r != 2'h0);
   assign out_data  = mem_r[rptr_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge sys_clk) begin
      if (reset) begin
         wptr_r  <= 1'b0;
         rptr_r  <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) begin
            mem_r[wptr_r] <= in_data;
            wptr_r        <= ~wptr_r;
         end
         if (pop)
            rptr_r <= ~rptr_r;
         if (push & ~pop)
            count_r <= count_r + 2'h1;
         else if (pop & ~push)
            count_r <= count_r - 2'h1;
      end
   end
endmodule

/* File: verilog/vector_graph_char_decoder.v */
/*
 * Byte-stream decoder turning host characters into drawing commands for a
 * frame-buffer engine: graph, point and incremental modes plus escapes.
 * Assumes the host byte stream is on sys_clk with a valid/ready handshake
 * and that the drawing engine accepts commands with cmd_valid/cmd_ready.
 */
`include "vecdec_defines.vh"
module vector_graph_char_decoder #(
   parameter COORD_W = 10,
   parameter INCR_W  = 12
) (
   // Clock and reset
   input  wire               sys_clk,
   input  wire               reset,
   // Host character stream
   input  wire               rx_valid,
   output reg                rx_ready,
   input  wire [7:0]         rx_byte,
   // Drawing engine command
   output reg                cmd_valid,
   input  wire               cmd_ready,
   output reg  [1:0]         cmd_kind,
   output reg                cmd_draw,
   output reg  [COORD_W-1:0] cmd_x0,
   output reg  [COORD_W-1:0] cmd_y0,
   output reg  [COORD_W-1:0] cmd_x1,
   output reg  [COORD_W-1:0] cmd_y1,
   output reg  [7:0]         cmd_char,
   // Mode status
   output reg  [3:0]         mode
);
   localparam PW = 2 + 1 + 4 * COORD_W + 8;

   // ==========================================================
   // Decoder state
   reg [3:0]         state_r;
   reg               esc_r;
   reg               first_r;
   reg               pen_r;
   reg               dark_sel_r;
   reg               last_ylow_r;
   reg [`HALF_W-1:0] yh_r, yl_r, xh_r, xl_r;
   reg [COORD_W-1:0] curx_r, cury_r;
   reg [INCR_W-1:0]  ix_r, iy_r;

   // Command word toward the buffer.
   reg               push;
   reg [1:0]         p_kind;
   reg               p_draw;
   reg [COORD_W-1:0] p_x1, p_y1;
   reg [7:0]         p_char;
   wire              buf_ready;
   wire              buf_valid;
   wire [PW-1:0]     buf_data;
   wire [PW-1:0]     push_data;

   wire [1:0]        tag   = rx_byte[`TAG_MSB:`TAG_LSB];
   wire [`HALF_W-1:0] low5 = rx_byte[`HALF_W-1:0];
   wire              take  = rx_valid & buf_ready;
   wire              graphic = (state_r == `ST_GRAPH) | (state_r == `ST_POINT);

   assign push_data = {p_kind, p_draw, curx_r, cury_r, p_x1, p_y1, p_char};

   // A byte is only taken when the buffer has room, so a stalled engine
   // backs up into the host stream and no command is dropped. [RQ23]
   always @* begin
      rx_ready = buf_ready;
   end

   vec_skid_buffer #(
      .WIDTH (PW)
   ) u_buf (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .in_valid  (push),
      .in_ready  (buf_ready),
      .in_data   (push_data),
      .out_valid (buf_valid),
      .out_ready (~cmd_valid | cmd_ready),
      .out_data  (buf_data)
   );

   // ==========================================================
   // Byte interpretation
   reg [3:0]         st_nxt;
   reg               esc_nxt, first_nxt, pen_nxt, dark_nxt, ylow_nxt;
   reg [`HALF_W-1:0] yh_nxt, yl_nxt, xh_nxt, xl_nxt;
   reg [COORD_W-1:0] curx_nxt, cury_nxt;
   reg [INCR_W-1:0]  ix_nxt, iy_nxt;
   reg               step;
   reg [INCR_W-1:0]  dx, dy;

   always @* begin
      st_nxt = state_r; esc_nxt = esc_r; first_nxt = first_r; pen_nxt = pen_r;
      dark_nxt = dark_sel_r; ylow_nxt = last_ylow_r;
      yh_nxt = yh_r; yl_nxt = yl_r; xh_nxt = xh_r; xl_nxt = xl_r;
      curx_nxt = curx_r; cury_nxt = cury_r; ix_nxt = ix_r; iy_nxt = iy_r;
      push = 1'b0; p_kind = `KIND_MOVE; p_draw = 1'b0;
      p_x1 = curx_r; p_y1 = cury_r; p_char = rx_byte;
      step = 1'b0; dx = {INCR_W{1'b0}}; dy = {INCR_W{1'b0}};
      if (take) begin
         if (rx_byte == `C_NUL) begin
            // Ignored everywhere, also inside an escape. [RQ13]
         end else if (esc_r) begin
            esc_nxt = 1'b0;
            if (rx_byte >= `W_DARK_LO && rx_byte <= `W_DARK_HI)
               dark_nxt = 1'b1; // [RQ19] [RQ22]
            else if ((rx_byte >= `W_WR1_LO && rx_byte <= `W_WR1_HI) ||
                     (rx_byte >= `W_WR2_LO && rx_byte <= `W_WR2_HI))
               dark_nxt = 1'b0; // [RQ20] [RQ22]
            else if (rx_byte == `C_QMARK) begin
               push = 1'b1; // [RQ21]
               p_kind = `KIND_DEL;
               p_char = `C_DEL;
            end
            // Every other escape code is dropped silently. [RQ22]
         end else if (rx_byte == `C_ESC) begin
            esc_nxt = 1'b1; // [RQ14]
         end else if (rx_byte == `C_GRAPH) begin
            st_nxt = `ST_GRAPH; // [RQ15]
            first_nxt = 1'b1; // [RQ2]
            ylow_nxt = 1'b0; // [RQ9]
         end else if (rx_byte == `C_POINT) begin
            st_nxt = `ST_POINT; // [RQ15]
            ylow_nxt = 1'b0;
         end else if (rx_byte == `C_INCR) begin
            st_nxt = `ST_INCR; // [RQ16]
            ix_nxt = {curx_r, {`FRAC_W{1'b0}}};
            iy_nxt = {cury_r, {`FRAC_W{1'b0}}};
         end else if (rx_byte == `C_ALPHA || rx_byte == `C_CR) begin
            st_nxt = `ST_ALPHA; // [RQ15]
            if (rx_byte == `C_CR) begin
               push = 1'b1;
               p_kind = `KIND_TEXT;
            end
         end else if (graphic) begin
            if (rx_byte == `C_BEL) begin
               if (state_r == `ST_GRAPH)
                  first_nxt = 1'b0; // [RQ3]
            end else if (tag == `TAG_HIGH) begin
               // The tag history picks which high half this is. [RQ8]
               if (last_ylow_r)
                  xh_nxt = low5;
               else
                  yh_nxt = low5; // [RQ6]
            end else if (tag == `TAG_YLOW) begin
               // An extra-precision byte comes as a first low-Y byte; the true low-Y
               // byte after it overwrites it, so the two extra bits are dropped. [RQ12]
               yl_nxt = low5; // [RQ7]
               ylow_nxt = 1'b1;
            end else if (tag == `TAG_XLOW) begin
               // Completes the address; held halves are reused. [RQ10] [RQ5]
               xl_nxt = low5;
               ylow_nxt = 1'b0;
               push = 1'b1;
               p_y1 = {yh_r, yl_r}; // [RQ6]
               p_x1 = {xh_r, low5};
               curx_nxt = {xh_r, low5}; // [RQ1]
               cury_nxt = {yh_r, yl_r};
               if (state_r == `ST_POINT) begin
                  p_kind = `KIND_POINT; // [RQ4]
                  p_draw = 1'b0;
               end else begin
                  p_kind = `KIND_MOVE; // [RQ1]
                  p_draw = ~first_r & ~dark_sel_r; // [RQ2] [RQ19] [RQ20]
                  first_nxt = 1'b0;
               end
            end
         end else if (state_r == `ST_INCR) begin
            case (rx_byte)
               `C_SPACE:  pen_nxt = 1'b0; // [RQ16]
               `C_PEN_DN: pen_nxt = 1'b1;
               `C_MV_R:   begin step = 1'b1; dx = `STEP_ONE; end
               `C_MV_RU:  begin step = 1'b1; dx = `STEP_ONE; dy = `STEP_ONE; end
               `C_MV_U:   begin step = 1'b1; dy = `STEP_ONE; end
               `C_MV_LU:  begin step = 1'b1; dx = -`STEP_ONE; dy = `STEP_ONE; end
               `C_MV_L:   begin step = 1'b1; dx = -`STEP_ONE; end
               `C_MV_LD:  begin step = 1'b1; dx = -`STEP_ONE; dy = -`STEP_ONE; end
               `C_MV_D:   begin step = 1'b1; dy = -`STEP_ONE; end
               `C_MV_RD:  begin step = 1'b1; dx = `STEP_ONE; dy = -`STEP_ONE; end
               default: begin
                  st_nxt = `ST_ALPHA; // [RQ17]
                  push = 1'b1;
                  p_kind = `KIND_TEXT;
               end
            endcase
            if (step) begin
               // Sub-pixel steps: only the top bits reach the screen. [RQ18]
               ix_nxt = ix_r + dx;
               iy_nxt = iy_r + dy;
               push = 1'b1;
               p_kind = `KIND_MOVE;
               p_draw = pen_r;
               p_x1 = ix_nxt[INCR_W-1:`FRAC_W];
               p_y1 = iy_nxt[INCR_W-1:`FRAC_W];
               curx_nxt = p_x1;
               cury_nxt = p_y1;
            end
         end else begin
            push = 1'b1;
            p_kind = `KIND_TEXT;
         end
      end
   end

   always @(posedge sys_clk) begin
      if (reset) begin
         state_r <= `ST_ALPHA; esc_r <= 1'b0; first_r <= 1'b1; pen_r <= 1'b0;
         dark_sel_r <= 1'b0; last_ylow_r <= 1'b0;
         yh_r <= 5'h00; yl_r <= 5'h00; xh_r <= 5'h00; xl_r <= 5'h00;
         curx_r <= {COORD_W{1'b0}}; cury_r <= {COORD_W{1'b0}};
         ix_r <= {INCR_W{1'b0}}; iy_r <= {INCR_W{1'b0}};
      end else begin
         state_r <= st_nxt; esc_r <= esc_nxt; first_r <= first_nxt; pen_r <= pen_nxt;
         dark_sel_r <= dark_nxt; last_ylow_r <= ylow_nxt;
         yh_r <= yh_nxt; yl_r <= yl_nxt; xh_r <= xh_nxt; xl_r <= xl_nxt;
         curx_r <= curx_nxt; cury_r <= cury_nxt; ix_r <= ix_nxt; iy_r <= iy_nxt;
      end
   end

   // ==========================================================
   // Output register stage
   always @(posedge sys_clk) begin
      if (reset) begin
         cmd_valid <= 1'b0; cmd_kind <= `KIND_MOVE; cmd_draw <= 1'b0;
         cmd_x0 <= {COORD_W{1'b0}}; cmd_y0 <= {COORD_W{1'b0}};
         cmd_x1 <= {COORD_W{1'b0}}; cmd_y1 <= {COORD_W{1'b0}};
         cmd_char <= 8'h00; mode <= `ST_ALPHA;
      end else begin
         mode <= state_r;
         if (~cmd_valid | cmd_ready) begin
            cmd_valid <= buf_valid; // [RQ23]
            if (buf_valid)
               {cmd_kind, cmd_draw, cmd_x0, cmd_y0, cmd_x1, cmd_y1, cmd_char} <= buf_data;
         end
      end
   end
endmodule

/* File: tb/vector_graph_char_decoder_asserts.sv */
/* Checker bound to the decoder, watching its ports only.
   Assumes one clock, with reset synchronous and active high. */
`include "vecdec_defines.vh"
module vecdec_checker #(
   parameter COORD_W = 10,
   parameter INCR_W  = 12
) (
   // Clock and reset
   input logic               sys_clk,
   input logic               reset,
   // Host stream
   input logic               rx_valid,
   input logic               rx_ready,
   input logic [7:0]         rx_byte,
   // Drawing command
   input logic               cmd_valid,
   input logic               cmd_ready,
   input logic [1:0]         cmd_kind,
   input logic               cmd_draw,
   input logic [COORD_W-1:0] cmd_x0,
   input logic [COORD_W-1:0] cmd_y0,
   input logic [COORD_W-1:0] cmd_x1,
   input logic [COORD_W-1:0] cmd_y1,
   input logic [7:0]         cmd_char,
   // Mode status
   input logic [3:0]         mode
);
   timeunit 1ns;
   timeprecision 1ns;
   logic               esc_r;
   logic               have_r;
   logic [COORD_W-1:0] px_r;
   logic [COORD_W-1:0] py_r;
   wire                take  = rx_valid && rx_ready;
   wire                plain = take && !esc_r;
   // ==========
   // Tracking
   // The escape flag keeps mode checks off bytes that only finish a sequence.
   always @(posedge sys_clk) begin
      if (reset) begin
         esc_r  <= 1'b0;
         have_r <= 1'b0;
         px_r   <= '0;
         py_r   <= '0;
      end else begin
         if (take) begin
            esc_r <= (rx_byte == `C_ESC) && !esc_r;
         end
         if (cmd_valid && cmd_ready && !cmd_kind[1]) begin
            have_r <= 1'b1;
            px_r   <= cmd_x1;
            py_r   <= cmd_y1;
         end
      end
   end
   // ==========
   // Properties
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   chk_cmd_hold:
      assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable({cmd_kind, cmd_draw,
         cmd_x0, cmd_y0, cmd_x1, cmd_y1, cmd_char})) else $error("command changed in stall");
   chk_start_pos:
      assert property (cmd_valid && !cmd_kind[1] && have_r |-> cmd_x0 == px_r && cmd_y0 == py_r)
      else $error("move does not start at current position");
   chk_point_dark:
      assert property (cmd_valid && cmd_kind == `KIND_POINT |-> !cmd_draw)
      else $error("point command drawn");
   chk_xlow_answer:
      assert property (plain && mode == `ST_GRAPH && rx_byte[7:5] == 3'b010 |-> ##[2:12]
         cmd_valid && cmd_kind == `KIND_MOVE) else $error("x low gave no move");
   chk_del_answer:
      assert property (take && esc_r && rx_byte == `C_QMARK |-> ##[2:12] cmd_valid &&
         cmd_kind == `KIND_DEL && cmd_char == `C_DEL) else $error("escape query not delete");
   chk_graph_entry:
      assert property (plain && rx_byte == `C_GRAPH |-> ##[1:12] mode == `ST_GRAPH)
      else $error("graph mode not entered");
   chk_point_entry:
      assert property (plain && rx_byte == `C_POINT |-> ##[1:12] mode == `ST_POINT)
      else $error("point mode not entered");
   chk_alpha_entry:
      assert property (plain && (rx_byte == `C_ALPHA || rx_byte == `C_CR) |-> ##[1:12]
         mode == `ST_ALPHA) else $error("alpha mode not entered");
   chk_incr_entry:
      assert property (plain && rx_byte == `C_INCR |-> ##[1:12] mode == `ST_INCR)
      else $error("incremental mode not entered");
   cover property (cmd_valid && cmd_draw && cmd_kind == `KIND_MOVE);
   cover property (rx_valid && !rx_ready);
   cover property (cmd_valid && cmd_kind == `KIND_TEXT);
endmodule
bind vector_graph_char_decoder vecdec_checker #(.COORD_W(COORD_W), .INCR_W(INCR_W)) chk (
   .sys_clk(sys_clk), .reset(reset), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .rx_byte(rx_byte), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
   .cmd_draw(cmd_draw), .cmd_x0(cmd_x0), .cmd_y0(cmd_y0), .cmd_x1(cmd_x1),
   .cmd_y1(cmd_y1), .cmd_char(cmd_char), .mode(mode));

/* File: tb/host_stream_model.sv */
/* Host model sending queued characters over rx_valid and rx_ready.
   Assumes the bench queues bytes with send and sets slow for gaps. */
module host_stream_model (
   // Clock and reset
   input  logic       sys_clk,
   input  logic       reset,
   // Pacing
   input  logic       slow,
   // Character stream
   input  logic       rx_ready,
   output logic       rx_valid,
   output logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] q[$];
   task send(input logic [7:0] b);
      q.push_back(b);
   endtask
   initial begin
      rx_valid = 1'b0;
      rx_byte  = 8'h00;
   end
   // ==========
   // Stream driver
   // Bytes leave in queue order, so Y goes before X as queued
   // An idle line inverts the byte lines every cycle so stale data cannot pass.
   always @(posedge sys_clk) begin
      if (reset) begin
         rx_valid <= 1'b0;
      end else begin
         if (rx_valid && rx_ready) begin
            void'(q.pop_front());
         end
         if (q.size() != 0 && !(slow && rx_valid && rx_ready)) begin
            rx_valid <= 1'b1;
            rx_byte  <= q[0];
         end else begin
            rx_valid <= 1'b0;
            rx_byte  <= ~rx_byte;
         end
      end
   end
endmodule

/* File: tb/vector_graph_char_decoder_tb.sv */
/* Self-checking bench for the vector graph character decoder.
   Assumes the host model and the bound checker are compiled first. */
`include "vecdec_defines.vh"
module vector_graph_char_decoder_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk, reset, slow, rx_valid, rx_ready, cmd_valid, cmd_ready, cmd_draw;
   logic [7:0]  rx_byte, cmd_char;
   logic [1:0]  cmd_kind;
   logic [9:0]  cmd_x0, cmd_y0, cmd_x1, cmd_y1;
   logic [3:0]  mode;
   logic [30:0] cq[$];
   logic [11:0] ix, iy;
   logic [7:0]  step_code [8] = '{`C_MV_R, `C_MV_RU, `C_MV_U, `C_MV_LU, `C_MV_L, `C_MV_LD,
                                  `C_MV_D, `C_MV_RD};
   int          dx [8] = '{1, 1, 0, -1, -1, -1, 0, 1};
   int          dy [8] = '{0, 1, 1, 1, 0, -1, -1, -1};
   int          num_errors = 0;
   int          checks_done = 0;
   host_stream_model host (.sys_clk(sys_clk), .reset(reset), .slow(slow),
      .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte));
   vector_graph_char_decoder #(.COORD_W(10), .INCR_W(12)) dut (.sys_clk(sys_clk),
      .reset(reset), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_draw(cmd_draw),
      .cmd_x0(cmd_x0), .cmd_y0(cmd_y0), .cmd_x1(cmd_x1), .cmd_y1(cmd_y1),
      .cmd_char(cmd_char), .mode(mode));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (cmd_valid && cmd_ready)
         cq.push_back({cmd_kind, cmd_draw, cmd_x1, cmd_y1, cmd_char});
   end
   // ==========
   // Shared tasks
   task check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task conclude;
      $display("checks_done %0d num_errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task put(input logic [7:0] b);
      host.send(b);
   endtask
   // Text and delete commands carry only the current position, so only kind and byte are judged.
   task exp_cmd(input logic [1:0] k, input logic d, input logic [9:0] x, input logic [9:0] y,
                input logic [7:0] c);
      logic [30:0] g;
      int          n;
      n = 0;
      while (cq.size() == 0 && n < 60) begin
         @(posedge sys_clk);
         n++;
      end
      if (cq.size() == 0) begin
         num_errors++;
         conclude();
      end else begin
         g = cq.pop_front();
         if (k[1])
            check({g[30:29], g[7:0]}, {k, c});
         else
            check(g[30:8], {k, d, x, y});
      end
   endtask
   task settle;
      int n;
      n = 0;
      while ((host.q.size() != 0 || rx_valid) && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      if (n == 200) begin
         num_errors++;
         conclude();
      end else
         repeat (4) @(posedge sys_clk);
   endtask
   // ==========
   // Scenarios
   task t_graph;
      put(`C_GRAPH);
      put(8'h2a);
      put(8'h75);
      put(8'h2b);
      put(8'h52);
      put(`C_NUL);
      put(8'h45);
      put(8'h61);
      put(8'h43);
      put(8'h62);
      put(8'h21);
      put(8'h40);
      put(8'h23);
      put(8'h44);
      exp_cmd(`KIND_MOVE, 1'b0, 10'h172, 10'h155, 8'h00);
      exp_cmd(`KIND_MOVE, 1'b1, 10'h165, 10'h155, 8'h00);
      exp_cmd(`KIND_MOVE, 1'b1, 10'h163, 10'h141, 8'h00);
      exp_cmd(`KIND_MOVE, 1'b1, 10'h020, 10'h142, 8'h00);
      exp_cmd(`KIND_MOVE, 1'b1, 10'h024, 10'h062, 8'h00);
      settle();
      check(mode, `ST_GRAPH);
   endtask
   task t_bell;
      put(8'h67);
      put(`C_GRAPH);
      put(`C_BEL);
      put(8'h22);
      put(8'h6b);
      put(8'h67);
      put(8'h49);
      exp_cmd(`KIND_MOVE, 1'b1, 10'h029, 10'h047, 8'h00);
   endtask
   task t_escape;
      logic d;
      d = 1'b1;
      for (int c = 8'h60; c <= 8'h74; c++) begin
         put(`C_ESC);
         put(c[7:0]);
         put({3'b010, c[4:0]});
         if (c >= `W_DARK_LO)
            d = 1'b0;
         else if (c <= `W_WR1_HI || (c >= `W_WR2_LO && c <= `W_WR2_HI))
            d = 1'b1;
         exp_cmd(`KIND_MOVE, d, {5'h01, c[4:0]}, 10'h047, 8'h00);
      end
      put(`C_ESC);
      put(`C_QMARK);
      exp_cmd(`KIND_DEL, 1'b0, 10'h000, 10'h000, `C_DEL);
   endtask
   task t_point;
      slow <= 1'b1;
      put(`C_POINT);
      put(8'h71);
      put(8'h42);
      exp_cmd(`KIND_POINT, 1'b0, 10'h022, 10'h051, 8'h00);
      settle();
      check(mode, `ST_POINT);
      slow <= 1'b0;
   endtask
   task t_incr;
      int n;
      ix = 12'h088;
      iy = 12'h144;
      cmd_ready <= 1'b0;
      put(`C_INCR);
      put(`C_PEN_DN);
      for (int i = 0; i < 8; i++)
         put(`C_MV_R);
      n = 0;
      while (rx_ready && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      check(rx_ready, 1'b0);
      check(mode, `ST_INCR);
      cmd_ready <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         ix = ix + 12'h001;
         exp_cmd(`KIND_MOVE, 1'b1, ix[11:2], iy[11:2], 8'h00);
      end
      put(`C_NUL);
      for (int i = 0; i < 8; i++) begin
         put(step_code[i]);
         ix = ix + 12'(dx[i]);
         iy = iy + 12'(dy[i]);
         exp_cmd(`KIND_MOVE, 1'b1, ix[11:2], iy[11:2], 8'h00);
      end
      put(`C_SPACE);
      put(`C_MV_U);
      iy = iy + 12'h001;
      exp_cmd(`KIND_MOVE, 1'b0, ix[11:2], iy[11:2], 8'h00);
      put(8'h5a);
      exp_cmd(`KIND_TEXT, 1'b0, 10'h000, 10'h000, 8'h5a);
      settle();
      check(mode, `ST_ALPHA);
   endtask
   task t_alpha;
      put(`C_GRAPH);
      put(`C_ALPHA);
      settle();
      check(mode, `ST_ALPHA);
      put(`C_POINT);
      put(`C_CR);
      exp_cmd(`KIND_TEXT, 1'b0, 10'h000, 10'h000, `C_CR);
      settle();
      check(mode, `ST_ALPHA);
   endtask
   initial begin
      reset = 1'b1;
      slow = 1'b0;
      cmd_ready = 1'b0;
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      cmd_ready <= 1'b1;
      @(posedge sys_clk);
      check(mode, `ST_ALPHA);
      t_graph();
      t_bell();
      t_escape();
      t_point();
      t_incr();
      t_alpha();
      conclude();
   end
endmodule
